// File: logic/mr1_pkg.sv
`default_nettype none
package mr1_pkg;
   localparam int MR_W = 19;
   localparam int ADDR_W = 16;
   localparam int BA_W = 3;
   localparam logic [2:0] BA_MR0 = 3'h0;
   localparam logic [2:0] BA_MR1 = 3'h1;
   localparam int MR0_DLL_RST_BIT = 8;
   localparam int DLL_EN_BIT = 0;
   localparam logic DLL_EN_LEVEL = 1'h0;
   localparam int DS_HI_BIT = 5;
   localparam int DS_LO_BIT = 1;
   localparam int RTT_B2 = 9;
   localparam int RTT_B1 = 6;
   localparam int RTT_B0 = 2;
   localparam int AL_HI_BIT = 4;
   localparam int AL_LO_BIT = 3;
   localparam int WL_BIT = 7;
   localparam int TDQS_BIT = 11;
   localparam int QOFF_BIT = 12;
   localparam logic [18:0] RSVD_MASK = 19'h4E500;
   localparam logic [18:0] MR1_RESET = 19'h00000;
   localparam logic [1:0] AL_ZERO = 2'h0;
   localparam logic [1:0] AL_CL_M1 = 2'h1;
   localparam logic [1:0] AL_CL_M2 = 2'h2;
   localparam logic [2:0] RTT_OFF = 3'h0;
   localparam logic [2:0] RTT_MAX_WR = 3'h3;
   localparam logic [3:0] DIV_RTT1 = 4'h4;
   localparam logic [3:0] DIV_RTT2 = 4'h2;
   localparam logic [3:0] DIV_RTT3 = 4'h6;
   localparam logic [3:0] DIV_RTT4 = 4'hC;
   localparam logic [3:0] DIV_RTT5 = 4'h8;
   localparam logic [3:0] LAT_DLL_OFF = 4'h6;
   localparam int DLL_LOCK_CK = 512;
   localparam int BURST_CK = 4;
   localparam int DLY_DEPTH = 16;
   typedef enum logic [1:0] {
      MR1_DLL_OFF     = 2'h0,
      MR1_DLL_LOCKING = 2'h1,
      MR1_DLL_LOCKED  = 2'h3,
      MR1_DLL_SUSP    = 2'h2
   } mr1_dll_e;
endpackage
`default_nettype wire

// File: logic/mr1_dly_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mr1_dly_if;
   logic       step;
   logic [1:0] cmd;
   logic [3:0] delay;
   logic [1:0] release_cmd;
   modport src (output step, output cmd, output delay, input release_cmd);
   modport dly (input step, input cmd, input delay, output release_cmd);
endinterface
`default_nettype wire

// File: logic/mr1_cmd_delay.sv
`timescale 1ns/1ps
`default_nettype none
module mr1_cmd_delay #(
   parameter int DEPTH = mr1_pkg::DLY_DEPTH
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   mr1_dly_if.dly    port_in
);
   localparam int AW = $clog2(DEPTH);
   logic [1:0]    mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [1:0]    rd_word;

   assign rd_ptr = wr_ptr - AW'(port_in.delay);
   assign rd_word = (port_in.delay == 4'h0) ? port_in.cmd : mem[rd_ptr];

   always_ff @(posedge clk_in) begin
      // a command released at once is stored as empty, so a later rise in
      // the delay cannot release it a second time
      if (port_in.step) begin
         mem[wr_ptr] <= (port_in.delay == 4'h0) ? 2'h0 : port_in.cmd;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         port_in.release_cmd <= 2'h0;
      end else begin
         port_in.release_cmd <= port_in.step ? rd_word : 2'h0;
         if (port_in.step) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
      end
   end

   zero_delay_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      port_in.step && port_in.delay == 4'h0 |=> port_in.release_cmd == $past(port_in.cmd))
      else $error("command with zero delay not released at once");
endmodule
`default_nettype wire

// File: logic/mr1_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - mode register set to register one stores bits until rewrite or reset pin.
// - rewriting the mode register never touches stored array data.
// - write leveling with outputs on allows only write-capable termination values.
// - enabled DLL stops on self refresh entry, restarts with reset on exit.
// - disabled DLL stays off after self refresh until enabled and reset.
// - DLL off forbids termination and forces cas read and write latency to six; additive latency still adds on top.
// - bit 12 set tri-states all data and strobe outputs.
// - bit 11 routes strobe termination to termination pair and drops data mask.
// - dynamic termination replaces nominal value during a write burst.
// - nonzero termination field lets the termination pin switch termination.
// - bit 7 places the device in write leveling mode.
// - additive latency field gives zero, latency minus one or minus two.
// - commands release after additive latency; read and write latencies add it.
// - DLL reset waits 512 link clocks before the DLL counts as locked.
module mr1_top (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ck_in,
   input  wire logic        pin_reset_n_in,
   input  wire logic        cke_in,
   input  wire logic        cs_n_in,
   input  wire logic        ras_n_in,
   input  wire logic        cas_n_in,
   input  wire logic        we_n_in,
   input  wire logic [2:0]  ba_in,
   input  wire logic [15:0] addr_in,
   input  wire logic        odt_in,
   input  wire logic [3:0]  cas_latency_in,
   input  wire logic [3:0]  cas_write_latency_in,
   input  wire logic        dyn_odt_en_in,
   output logic [18:0]      mode_register_one_out,
   output logic             dll_running_out,
   output logic             dll_locked_out,
   output logic             self_refresh_out,
   output logic [1:0]       drive_strength_out,
   output logic             dq_oe_n_out,
   output logic             dm_enable_out,
   output logic             tdqs_term_en_out,
   output logic             rtt_on_out,
   output logic             rtt_use_wr_out,
   output logic [3:0]       rtt_divisor_out,
   output logic             write_level_out,
   output logic [4:0]       read_latency_out,
   output logic [4:0]       write_latency_out,
   output logic             read_release_out,
   output logic             write_release_out
);
   localparam int PW = 27;
   logic [PW-1:0]          pin_s1;
   logic [PW-1:0]          pin_s2;
   logic                   ck_prev;
   logic                   cke_prev;
   logic                   tick;
   logic                   s_ck;
   logic                   s_rst_n;
   logic                   s_cke;
   logic                   s_cs_n;
   logic                   s_ras_n;
   logic                   s_cas_n;
   logic                   s_we_n;
   logic                   s_odt;
   logic [2:0]             s_ba;
   logic [15:0]            s_addr;
   logic                   cmd_mrs;
   logic                   cmd_ref;
   logic                   cmd_rd;
   logic                   cmd_wr;
   logic                   mrs_mr1;
   logic                   dll_rst_cmd;
   logic                   sr_entry;
   logic                   sr_exit;
   logic [18:0]            mr1;
   logic [18:0]            next_mr1;
   logic                   dll_enabled;
   mr1_pkg::mr1_dll_e      dll_state;
   logic [9:0]             lock_cnt;
   logic [2:0]             rtt_code;
   logic                   rtt_allowed;
   logic [3:0]             next_div;
   logic [1:0]             al_code;
   logic [3:0]             cl_eff;
   logic [3:0]             cwl_eff;
   logic [4:0]             al_val;
   logic [2:0]             wr_busy;
   mr1_dly_if              dly ();

   // every pin sampled by two flip-flops before use
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         ck_prev <= 1'b0;
      end else begin
         pin_s1 <= {ck_in, pin_reset_n_in, cke_in, cs_n_in, ras_n_in, cas_n_in,
                    we_n_in, odt_in, ba_in, addr_in};
         pin_s2 <= pin_s1;
         ck_prev <= s_ck;
      end
   end

   assign {s_ck, s_rst_n, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_odt,
           s_ba, s_addr} = pin_s2;
   assign tick = s_ck && !ck_prev;

   assign cmd_mrs = tick && !s_cs_n && !s_ras_n && !s_cas_n && !s_we_n;
   assign cmd_ref = tick && !s_cs_n && !s_ras_n && !s_cas_n && s_we_n;
   assign cmd_rd = tick && s_cke && !s_cs_n && s_ras_n && !s_cas_n && s_we_n;
   assign cmd_wr = tick && s_cke && !s_cs_n && s_ras_n && !s_cas_n && !s_we_n;
   assign mrs_mr1 = cmd_mrs && s_ba == mr1_pkg::BA_MR1;
   assign dll_rst_cmd = cmd_mrs && s_ba == mr1_pkg::BA_MR0
                        && s_addr[mr1_pkg::MR0_DLL_RST_BIT];
   assign sr_entry = cmd_ref && cke_prev && !s_cke && !self_refresh_out;
   assign sr_exit = tick && s_cke && self_refresh_out;

   // register image: ba bits land on 18:16, address on 15:0
   assign next_mr1 = {s_ba, s_addr};

   // stored until rewritten or the reset pin falls; no array access here
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mr1 <= mr1_pkg::MR1_RESET;
      end else if (!s_rst_n) begin
         mr1 <= mr1_pkg::MR1_RESET;
      end else if (mrs_mr1) begin
         mr1 <= next_mr1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cke_prev <= 1'b0;
         self_refresh_out <= 1'b0;
      end else if (!s_rst_n) begin
         cke_prev <= 1'b0;
         self_refresh_out <= 1'b0;
      end else if (tick) begin
         cke_prev <= s_cke;
         if (sr_entry) begin
            self_refresh_out <= 1'b1;
         end else if (sr_exit) begin
            self_refresh_out <= 1'b0;
         end
      end
   end

   assign dll_enabled = mr1[mr1_pkg::DLL_EN_BIT] == mr1_pkg::DLL_EN_LEVEL;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dll_state <= mr1_pkg::MR1_DLL_OFF;
         lock_cnt <= '0;
      end else if (!s_rst_n) begin
         dll_state <= mr1_pkg::MR1_DLL_OFF;
         lock_cnt <= '0;
      end else begin
         unique case (dll_state)
            mr1_pkg::MR1_DLL_OFF: begin
               if (dll_rst_cmd && dll_enabled) begin
                  dll_state <= mr1_pkg::MR1_DLL_LOCKING;
                  lock_cnt <= '0;
               end
            end
            mr1_pkg::MR1_DLL_LOCKING: begin
               if (sr_entry) begin
                  dll_state <= mr1_pkg::MR1_DLL_SUSP;
               end else if (!dll_enabled) begin
                  dll_state <= mr1_pkg::MR1_DLL_OFF;
               end else if (dll_rst_cmd) begin
                  lock_cnt <= '0;
               end else if (tick && s_cke) begin
                  if (lock_cnt == 10'(mr1_pkg::DLL_LOCK_CK - 1)) begin
                     dll_state <= mr1_pkg::MR1_DLL_LOCKED;
                  end
                  lock_cnt <= lock_cnt + 10'h001;
               end
            end
            mr1_pkg::MR1_DLL_LOCKED: begin
               if (sr_entry) begin
                  dll_state <= mr1_pkg::MR1_DLL_SUSP;
               end else if (!dll_enabled) begin
                  dll_state <= mr1_pkg::MR1_DLL_OFF;
               end else if (dll_rst_cmd) begin
                  dll_state <= mr1_pkg::MR1_DLL_LOCKING;
                  lock_cnt <= '0;
               end
            end
            mr1_pkg::MR1_DLL_SUSP: begin
               if (sr_exit) begin
                  dll_state <= mr1_pkg::MR1_DLL_LOCKING;
                  lock_cnt <= '0;
               end
            end
         endcase
      end
   end

   assign dll_running_out = dll_state == mr1_pkg::MR1_DLL_LOCKING
                            || dll_state == mr1_pkg::MR1_DLL_LOCKED;
   assign dll_locked_out = dll_state == mr1_pkg::MR1_DLL_LOCKED;

   assign rtt_code = {mr1[mr1_pkg::RTT_B2], mr1[mr1_pkg::RTT_B1], mr1[mr1_pkg::RTT_B0]};
   // leveling with outputs enabled keeps only the write-capable codes
   assign rtt_allowed = !mr1[mr1_pkg::WL_BIT] || mr1[mr1_pkg::QOFF_BIT]
                        || rtt_code <= mr1_pkg::RTT_MAX_WR;

   always_comb begin
      unique case (rtt_code)
         3'h1: next_div = mr1_pkg::DIV_RTT1;
         3'h2: next_div = mr1_pkg::DIV_RTT2;
         3'h3: next_div = mr1_pkg::DIV_RTT3;
         3'h4: next_div = mr1_pkg::DIV_RTT4;
         3'h5: next_div = mr1_pkg::DIV_RTT5;
         default: next_div = 4'h0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_busy <= '0;
      end else if (write_release_out) begin
         wr_busy <= 3'(mr1_pkg::BURST_CK);
      end else if (tick && wr_busy != 3'h0) begin
         wr_busy <= wr_busy - 3'h1;
      end
   end

   // termination and pad control
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         drive_strength_out <= 2'h0;
         dq_oe_n_out <= 1'b0;
         dm_enable_out <= 1'b1;
         tdqs_term_en_out <= 1'b0;
         rtt_on_out <= 1'b0;
         rtt_use_wr_out <= 1'b0;
         rtt_divisor_out <= 4'h0;
         write_level_out <= 1'b0;
      end else begin
         drive_strength_out <= {mr1[mr1_pkg::DS_HI_BIT], mr1[mr1_pkg::DS_LO_BIT]};
         dq_oe_n_out <= mr1[mr1_pkg::QOFF_BIT];
         dm_enable_out <= !mr1[mr1_pkg::TDQS_BIT];
         tdqs_term_en_out <= mr1[mr1_pkg::TDQS_BIT] && rtt_on_out;
         rtt_on_out <= rtt_code != mr1_pkg::RTT_OFF && s_odt && rtt_allowed
                       && dll_enabled && !self_refresh_out;
         rtt_use_wr_out <= dyn_odt_en_in && wr_busy != 3'h0
                           && !mr1[mr1_pkg::WL_BIT];
         rtt_divisor_out <= rtt_allowed ? next_div : 4'h0;
         write_level_out <= mr1[mr1_pkg::WL_BIT];
      end
   end

   assign al_code = {mr1[mr1_pkg::AL_HI_BIT], mr1[mr1_pkg::AL_LO_BIT]};
   assign cl_eff = dll_enabled ? cas_latency_in : mr1_pkg::LAT_DLL_OFF;
   assign cwl_eff = dll_enabled ? cas_write_latency_in : mr1_pkg::LAT_DLL_OFF;

   always_comb begin
      unique case (al_code)
         mr1_pkg::AL_CL_M1: al_val = 5'(cl_eff) - 5'h01;
         mr1_pkg::AL_CL_M2: al_val = 5'(cl_eff) - 5'h02;
         default: al_val = 5'h00;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         read_latency_out <= 5'h00;
         write_latency_out <= 5'h00;
      end else begin
         read_latency_out <= al_val + 5'(cl_eff);
         write_latency_out <= al_val + 5'(cwl_eff);
      end
   end

   assign dly.step = tick;
   assign dly.cmd = {cmd_wr, cmd_rd};
   assign dly.delay = al_val[3:0];

   mr1_cmd_delay #(
      .DEPTH   (mr1_pkg::DLY_DEPTH)
   ) u_delay (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .port_in  (dly.dly)
   );

   assign read_release_out = dly.release_cmd[0];
   assign write_release_out = dly.release_cmd[1];
   assign mode_register_one_out = mr1;

   mrs_store_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mrs_mr1 && s_rst_n |=> mr1 == $past(next_mr1))
      else $error("register one not loaded by mode set");
   pin_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !s_rst_n |=> mr1 == mr1_pkg::MR1_RESET && !dll_running_out)
      else $error("reset pin did not clear register");
   qoff_pads_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ##1 dq_oe_n_out == $past(mr1[mr1_pkg::QOFF_BIT]))
      else $error("output disable not followed");
   tdqs_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mr1[mr1_pkg::TDQS_BIT] |=> !dm_enable_out)
      else $error("data mask active with termination strobe");
   sr_stop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sr_entry && s_rst_n |=> !dll_running_out ##0 self_refresh_out)
      else $error("DLL still running in self refresh");
   sr_restart_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sr_exit && dll_state == mr1_pkg::MR1_DLL_SUSP && s_rst_n
      |=> dll_running_out && !dll_locked_out && lock_cnt == 10'h000)
      else $error("DLL not reset on self refresh exit");
   sr_keep_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sr_exit && dll_state == mr1_pkg::MR1_DLL_OFF |=> !dll_running_out)
      else $error("disabled DLL woke after self refresh");
   dll_off_odt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !dll_enabled ##1 !dll_enabled |-> !rtt_on_out && read_latency_out >= 5'h06)
      else $error("termination or latency wrong with DLL off");
   level_rtt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mr1[mr1_pkg::WL_BIT] && !mr1[mr1_pkg::QOFF_BIT] && rtt_code > mr1_pkg::RTT_MAX_WR
      ##1 $stable(mr1) |-> !rtt_on_out)
      else $error("non-write termination used in leveling");
   lock_wait_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(dll_locked_out) |-> $past(lock_cnt) == 10'(mr1_pkg::DLL_LOCK_CK - 1))
      else $error("DLL locked before 512 link clocks");
   read_lat_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rst_n_in && $stable(mr1) && $stable(cas_latency_in) ##1 $stable(mr1)
      && $stable(cas_latency_in) |-> read_latency_out == 5'(cl_eff)
      + (al_code == mr1_pkg::AL_CL_M1 ? 5'(cl_eff) - 5'h01
      : al_code == mr1_pkg::AL_CL_M2 ? 5'(cl_eff) - 5'h02 : 5'h00))
      else $error("read latency not additive plus cas");

   mrs_seen_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) mrs_mr1);
   sr_cycle_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      sr_exit && dll_state == mr1_pkg::MR1_DLL_SUSP);
   lock_done_c: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(dll_locked_out));
   posted_rd_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      read_release_out && al_val != 5'h00);
endmodule
`default_nettype wire

// File: tb/mr1_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mr1_ctrl_model #(
   parameter int DEV_WIDTH = 8
) (
   input  wire logic   clk_in,
   output logic        ck_out,
   output logic        cke_out,
   output logic        cs_n_out,
   output logic [2:0]  cmd_n_out,
   output logic [2:0]  ba_out,
   output logic [15:0] addr_out
);
   logic [2:0] phase = 3'h0;
   // free-running command clock, eight system clocks a period
   always @(posedge clk_in) begin
      phase <= phase + 3'h1;
   end
   assign ck_out = phase[2];
   initial begin
      cke_out = 1'b1;
      cs_n_out = 1'b1;
      cmd_n_out = 3'h7;
      {ba_out, addr_out} = 19'h00000;
   end
   // pins change as the command clock falls and hold across its next rise
   task automatic issue(input logic [2:0] cmd, input logic [18:0] val, input logic cke);
      logic [18:0] v;
      v = val;
      if (cmd == 3'h0 && val[18:16] == mr1_pkg::BA_MR1) begin
         v = val & ~mr1_pkg::RSVD_MASK;
         // termination strobe exists only on by-eight parts
         if (DEV_WIDTH != 8) begin
            v[mr1_pkg::TDQS_BIT] = 1'b0;
         end
      end
      do @(negedge clk_in); while (phase != 3'h7);
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      cmd_n_out <= cmd;
      {ba_out, addr_out} <= v;
      cke_out <= cke;
      do @(negedge clk_in); while (phase != 3'h7);
      @(posedge clk_in);
      cs_n_out <= 1'b1;
      cmd_n_out <= ~cmd;
      {ba_out, addr_out} <= ~v;
      // one idle command period covers the mode gap
      repeat (8) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// File: tb/mr1_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mr1_top_tb;
   localparam logic [2:0] MRS = 3'h0;
   localparam logic [2:0] REF = 3'h1;
   localparam logic [2:0] RD  = 3'h5;
   localparam logic [2:0] WR  = 3'h4;
   localparam logic [2:0] NOP = 3'h7;
   logic        clk_in = 1'b0;
   logic        rst_n_in, pin_reset_n_in, odt_in, dyn_odt_en_in;
   logic [3:0]  cas_latency_in, cas_write_latency_in;
   logic        ck_in, cke_in, cs_n_in;
   logic [2:0]  cmd_n, ba_in;
   logic [15:0] addr_in;
   logic [18:0] mode_register_one_out;
   logic        dll_running_out, dll_locked_out, self_refresh_out, dq_oe_n_out;
   logic        dm_enable_out, tdqs_term_en_out, rtt_on_out, rtt_use_wr_out;
   logic        write_level_out, read_release_out, write_release_out;
   logic [1:0]  drive_strength_out;
   logic [3:0]  rtt_divisor_out;
   logic [4:0]  read_latency_out, write_latency_out;
   int          failures = 0;
   int          tests_run = 0;
   int          n;
   logic [3:0]  div [6] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8};
   logic [4:0]  alv;

   always #10 clk_in = ~clk_in;

   mr1_ctrl_model mr1_ctrl_model_inst (.clk_in, .ck_out(ck_in), .cke_out(cke_in),
      .cs_n_out(cs_n_in), .cmd_n_out(cmd_n), .ba_out(ba_in), .addr_out(addr_in));
   mr1_top mr1_top_inst (.clk_in, .rst_n_in, .ck_in, .pin_reset_n_in, .cke_in, .cs_n_in,
      .ras_n_in(cmd_n[2]), .cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]), .ba_in, .addr_in,
      .odt_in, .cas_latency_in, .cas_write_latency_in, .dyn_odt_en_in,
      .mode_register_one_out, .dll_running_out, .dll_locked_out, .self_refresh_out,
      .drive_strength_out, .dq_oe_n_out, .dm_enable_out, .tdqs_term_en_out, .rtt_on_out,
      .rtt_use_wr_out, .rtt_divisor_out, .write_level_out, .read_latency_out,
      .write_latency_out, .read_release_out, .write_release_out);

   task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // drive strength field at the 34 ohm setting in every write
   task automatic mr1(input logic [15:0] a);
      mr1_ctrl_model_inst.issue(MRS, {mr1_pkg::BA_MR1, a | 16'h0002}, 1'b1);
   endtask
   function automatic logic [15:0] rtt(input logic [2:0] c);
      return {6'h00, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0};
   endfunction
   task automatic lock_wait();
      n = 0;
      while (dll_locked_out !== 1'b1 && n < 5000) begin
         @(negedge clk_in);
         n++;
      end
   endtask
   // time from the command clock rise to the release pulse
   task automatic meas(input logic [2:0] cmd, input logic [4:0] al);
      fork
         mr1_ctrl_model_inst.issue(cmd, 19'h00000, 1'b1);
         begin
            wait (cs_n_in === 1'b0);
            @(posedge ck_in);
            n = 0;
            while ((cmd == RD ? read_release_out : write_release_out) !== 1'b1 && n < 200) begin
               @(negedge clk_in);
               n++;
            end
            chk("release delay", 1, n >= 8 * al && n <= 8 * al + 6);
            repeat (3) @(negedge clk_in);
            chk("write substitution", cmd == WR, rtt_use_wr_out);
         end
      join
   endtask

   initial begin
      {rst_n_in, pin_reset_n_in, odt_in, dyn_odt_en_in} = 4'h7;
      rst_n_in = 1'b0;
      cas_latency_in = 4'h6;
      cas_write_latency_in = 4'h5;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk("register reset", 19'h00000, mode_register_one_out);
      chk("mask reset", 1, dm_enable_out);
      // dll reset through register zero after enabling
      mr1_ctrl_model_inst.issue(MRS, 19'h00100, 1'b1);
      chk("dll running", 1, dll_running_out);
      repeat (4000) @(posedge clk_in);
      chk("dll early", 0, dll_locked_out);
      lock_wait();
      chk("dll locked", 1, dll_locked_out);
      mr1(16'h1800);
      chk("register", 19'h11802, mode_register_one_out);
      chk("outputs off", 1, dq_oe_n_out);
      chk("mask off", 0, dm_enable_out);
      chk("drive", 2'h1, drive_strength_out);
      odt_in <= 1'b1;
      for (int c = 0; c < 6; c++) begin
         mr1(rtt(c[2:0]));
         chk("divisor", div[c], rtt_divisor_out);
         chk("term on", c != 0, rtt_on_out);
      end
      odt_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      chk("term pin low", 0, rtt_on_out);
      odt_in <= 1'b1;
      mr1(16'h0800 | rtt(3'h1));
      chk("strobe term", 1, tdqs_term_en_out);
      mr1(16'h0080 | rtt(3'h4));
      chk("leveling", 1, write_level_out);
      chk("level term", 0, rtt_on_out);
      mr1(16'h1080 | rtt(3'h4));
      chk("level term", 1, rtt_on_out);
      mr1(16'h0080 | rtt(3'h2));
      chk("level term", 1, rtt_on_out);
      odt_in <= 1'b0;
      for (int a = 0; a < 4; a++) begin
         mr1({11'h000, a[1:0], 3'h0});
         // code 3 is no posting value and falls back to zero
         alv = (a == 0 || a == 3) ? 5'h00 : 5'h06 - 5'(a);
         chk("read latency", alv + 5'h06, read_latency_out);
         chk("write latency", alv + 5'h05, write_latency_out);
         meas(RD, alv);
         meas(WR, alv);
      end
      odt_in <= 1'b1;
      mr1(rtt(3'h1) | {15'h0000, ~mr1_pkg::DLL_EN_LEVEL});
      chk("dll off read", 6, read_latency_out);
      chk("dll off write", 6, write_latency_out);
      chk("dll off term", 0, rtt_on_out);
      mr1_ctrl_model_inst.issue(REF, 19'h00000, 1'b0);
      chk("self refresh", 1, self_refresh_out);
      mr1_ctrl_model_inst.issue(NOP, 19'h00000, 1'b1);
      chk("self refresh exit", 0, self_refresh_out);
      chk("dll stays off", 0, dll_running_out);
      odt_in <= 1'b0;
      mr1(16'h0000);
      mr1_ctrl_model_inst.issue(MRS, 19'h00100, 1'b1);
      lock_wait();
      chk("dll relocked", 1, dll_locked_out);
      mr1_ctrl_model_inst.issue(REF, 19'h00000, 1'b0);
      chk("dll stopped", 0, dll_running_out);
      mr1_ctrl_model_inst.issue(NOP, 19'h00000, 1'b1);
      chk("dll restarted", 1, dll_running_out);
      chk("dll relocking", 0, dll_locked_out);
      pin_reset_n_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      pin_reset_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk("pin reset", 19'h00000, mode_register_one_out);
      chk("pin reset dll", 0, dll_running_out);
      summarize();
   end

   initial begin
      #1000000;
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
